// >>> rtl/ubg_pkg.sv
package ubg_pkg;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] ModeOffset   = 8'h00;
  localparam logic [7:0] CtrlOffset   = 8'h08;
  localparam logic [7:0] BaudOffset   = 8'h0c;
  localparam logic [7:0] GuardOffset  = 8'h10;
  localparam logic [7:0] StatusOffset = 8'h20;
  localparam logic [7:0] MaskOffset   = 8'h24;
  localparam logic [7:0] StateOffset  = 8'h28;

  // ****************************************
  // field positions
  // ****************************************
  localparam int ModeEnPos      = 0;
  localparam int ModeScPos      = 1;
  localparam int ModeIrPos      = 2;
  localparam int ModeIrLpPos    = 3;
  localparam int CtrlDrvEnPos   = 14;
  localparam int CtrlDrvPolPos  = 15;
  localparam int CtrlRetryLsb   = 17;
  localparam int CtrlWakeSelLsb = 20;
  localparam int CtrlWakeIePos  = 22;
  localparam int BaudFracLsb    = 0;
  localparam int BaudIntLsb     = 4;
  localparam int GuardPscLsb    = 0;
  localparam int GuardTimeLsb   = 8;
  localparam int StsWakePos     = 0;
  localparam int StsTxDonePos   = 1;
  localparam int StsTxErrPos    = 2;
  localparam int StsRxErrPos    = 3;
  localparam int StsAutoBaudPos = 4;
  localparam int StsWidth       = 5;

  // ****************************************
  // reset values and constants
  // ****************************************
  localparam logic [3:0]  ModeReset  = 4'h0;
  localparam logic [31:0] CtrlReset  = 32'h0;
  localparam logic [15:0] BaudReset  = 16'h0;
  localparam logic [15:0] GuardReset = 16'h0;
  localparam logic [16:0] BaudStep   = 17'h00010;
  localparam logic [1:0]  WakeAddr   = 2'h0;
  localparam logic [1:0]  WakeStart  = 2'h2;
  localparam logic [1:0]  WakeRxFull = 2'h3;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic txFrameActive;
    logic txFrameDone;
    logic txNack;
    logic rxParityErr;
    logic rxGoodFrame;
    logic addrMatch;
    logic startDetect;
    logic rxNotEmpty;
  } ubg_evt_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] value;
  } ubg_autobaud_t;

  typedef enum logic [1:0] {
    GuardIdle,
    GuardWait,
    GuardDone
  } ubg_guard_t;

endpackage : ubg_pkg

// >>> rtl/ubg_config.sv
// Function
// - driver enable bit 14 puts the transceiver drive signal on the rts pin
// - polarity bit 15: clear gives active high, set gives active low
// - divider and config fields except wakeup interrupt enable take writes only while unit is disabled
// - retry count zero disables any automatic resend
// - smartcard transmit resends up to retry count, then reports error
// - smartcard receive retries up to retry count, then reports error
// - wakeup select: 00 address, 01 none, 10 start bit, 11 rx not empty
// - wakeup interrupt enable raises interrupt when wakeup flag sets
// - baud bits 3:0 hold the divider fraction
// - baud bits 15:4 hold the twelve bit divider integer
// - auto baud detection may overwrite the baud register
// - infrared low power divides clock by prescaler 1..255, zero reserved
// - smartcard uses prescaler 4:0, divides by twice value, zero reserved
// - smartcard transmit complete waits guard time in baud periods
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
`default_nettype none
module ubg_config
  import ubg_pkg::*;
(
  input  wire logic          clock,
  input  wire logic          resetn,
  input  wire logic [7:0]    addr,
  input  wire logic [31:0]   wdata,
  input  wire logic          wrStb,
  input  wire logic          rdStb,
  output logic      [31:0]   rdata,
  input  wire ubg_evt_t      evt,
  input  wire ubg_autobaud_t autoBaud,
  input  wire logic          rtsFlowLevel,
  output logic               rtsPin,
  output logic               baudTick,
  output logic               irdaTick,
  output logic               smartcardClock,
  output logic               txResend,
  output logic               rxRetryReq,
  output logic               txComplete,
  output logic               irq
);

  // ****************************************
  // register bus decode
  // ****************************************
  logic [31:0] rdata_qq;
  logic [3:0]  mode_q;
  logic [31:0] ctrl_q;
  logic [15:0] baud_q;
  logic [15:0] guard_q;
  logic [StsWidth-1:0] sts_q;
  logic [StsWidth-1:0] mask_q;
  logic [StsWidth-1:0] evtSet;
  logic        unitEn;
  logic        cfgWrOk;
  logic        scMode;
  logic        irLp;

  assign unitEn  = mode_q[ModeEnPos];
  assign scMode  = mode_q[ModeScPos];
  assign irLp    = mode_q[ModeIrPos] & mode_q[ModeIrLpPos];
  assign cfgWrOk = wrStb & ~unitEn;
  assign rdata   = rdata_qq;

  // ****************************************
  // mode register
  // ****************************************
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      mode_q <= ModeReset;
    end else if (wrStb && addr == ModeOffset) begin
      mode_q[ModeEnPos] <= wdata[ModeEnPos];
      if (!unitEn) begin
        mode_q[ModeIrLpPos:ModeScPos] <= wdata[ModeIrLpPos:ModeScPos];
      end
    end
  end

  // ****************************************
  // control register
  // ****************************************
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ctrl_q <= CtrlReset;
    end else if (wrStb && addr == CtrlOffset) begin
      ctrl_q[CtrlWakeIePos] <= wdata[CtrlWakeIePos];
      if (cfgWrOk) begin
        ctrl_q[CtrlDrvPolPos:CtrlDrvEnPos] <=
          wdata[CtrlDrvPolPos:CtrlDrvEnPos];
        ctrl_q[CtrlWakeSelLsb+1:CtrlRetryLsb] <=
          wdata[CtrlWakeSelLsb+1:CtrlRetryLsb];
      end
    end
  end

  logic       drvEn;
  logic       drvPol;
  logic [2:0] retryMax;
  logic [1:0] wakeSel;
  logic       wakeIe;

  assign drvEn    = ctrl_q[CtrlDrvEnPos];
  assign drvPol   = ctrl_q[CtrlDrvPolPos];
  assign retryMax = ctrl_q[CtrlRetryLsb+2:CtrlRetryLsb];
  assign wakeSel  = ctrl_q[CtrlWakeSelLsb+1:CtrlWakeSelLsb];
  assign wakeIe   = ctrl_q[CtrlWakeIePos];

  // ****************************************
  // baud and guard registers
  // ****************************************
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      baud_q <= BaudReset;
    end else if (autoBaud.valid) begin
      baud_q <= autoBaud.value;
    end else if (cfgWrOk && addr == BaudOffset) begin
      baud_q <= wdata[15:0];
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      guard_q <= GuardReset;
    end else if (cfgWrOk && addr == GuardOffset) begin
      guard_q <= wdata[15:0];
    end
  end

  logic [7:0] clock_prescaler;
  logic [7:0] guardTime;
  assign clock_prescaler       = guard_q[GuardPscLsb+7:GuardPscLsb];
  assign guardTime = guard_q[GuardTimeLsb+7:GuardTimeLsb];

  // ****************************************
  // baud tick generator
  // ****************************************
  logic [16:0] baudAcc_q;
  logic [16:0] baudAcc_d;
  logic [16:0] baudDiv;
  logic        baudHit;
  logic        baudTick_q;

  assign baudDiv = {1'b0, baud_q};

  always_comb begin
    baudAcc_d = baudAcc_q + BaudStep;
    baudHit   = 1'b0;
    if (baudAcc_d >= baudDiv) begin
      baudAcc_d = baudAcc_d - baudDiv;
      baudHit   = 1'b1;
    end
    if (!unitEn || baudDiv < BaudStep) begin
      baudAcc_d = '0;
      baudHit   = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      baudAcc_q  <= '0;
      baudTick_q <= 1'b0;
    end else begin
      baudAcc_q  <= baudAcc_d;
      baudTick_q <= baudHit;
    end
  end

  assign baudTick = baudTick_q;

  // ****************************************
  // prescaler
  // ****************************************
  logic [7:0] pscCnt_q;
  logic [7:0] pscLimit;
  logic       pscHit;
  logic       irdaTick_q;
  logic       scClock_q;

  always_comb begin
    pscLimit = 8'h00;
    if (scMode) begin
      pscLimit = {3'h0, clock_prescaler[4:0]};
    end else if (irLp) begin
      pscLimit = clock_prescaler;
    end
  end

  assign pscHit = (pscLimit != 8'h00) && (pscCnt_q == pscLimit - 8'h01);

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pscCnt_q <= 8'h00;
    end else if (!unitEn || pscLimit == 8'h00 || pscHit) begin
      pscCnt_q <= 8'h00;
    end else begin
      pscCnt_q <= pscCnt_q + 8'h01;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      irdaTick_q <= 1'b0;
      scClock_q  <= 1'b0;
    end else begin
      irdaTick_q <= pscHit && irLp && !scMode;
      if (!unitEn || !scMode) begin
        scClock_q <= 1'b0;
      end else if (pscHit) begin
        scClock_q <= ~scClock_q;
      end
    end
  end

  assign irdaTick       = irdaTick_q;
  assign smartcardClock = scClock_q;

  // ****************************************
  // driver enable pin
  // ****************************************
  logic rtsPin_q;
  logic drvActive;

  assign drvActive = evt.txFrameActive;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rtsPin_q <= 1'b1;
    end else if (drvEn) begin
      rtsPin_q <= drvActive ^ drvPol;
    end else begin
      rtsPin_q <= rtsFlowLevel;
    end
  end

  assign rtsPin = rtsPin_q;

  // ****************************************
  // smartcard retries
  // ****************************************
  logic [2:0] txTries_q;
  logic [2:0] rxTries_q;
  logic       txResend_q;
  logic       rxRetry_q;
  logic       txErr;
  logic       rxErr;
  logic       txOk;

  assign txErr = scMode && evt.txFrameDone && evt.txNack &&
                 txTries_q >= retryMax;
  assign rxErr = scMode && evt.rxParityErr &&
                 rxTries_q >= retryMax;
  assign txOk  = evt.txFrameDone && !(scMode && evt.txNack);

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      txTries_q  <= 3'h0;
      txResend_q <= 1'b0;
    end else begin
      txResend_q <= 1'b0;
      if (!unitEn || txOk || txErr) begin
        txTries_q <= 3'h0;
      end else if (scMode && evt.txFrameDone && evt.txNack) begin
        txTries_q  <= txTries_q + 3'h1;
        txResend_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rxTries_q <= 3'h0;
      rxRetry_q <= 1'b0;
    end else begin
      rxRetry_q <= 1'b0;
      if (!unitEn || evt.rxGoodFrame || rxErr) begin
        rxTries_q <= 3'h0;
      end else if (scMode && evt.rxParityErr) begin
        rxTries_q <= rxTries_q + 3'h1;
        rxRetry_q <= 1'b1;
      end
    end
  end

  assign txResend   = txResend_q;
  assign rxRetryReq = rxRetry_q;

  // ****************************************
  // guard time
  // ****************************************
  ubg_guard_t guardSt_q;
  logic [7:0] guardCnt_q;
  logic       txComplete_q;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      guardSt_q  <= GuardIdle;
      guardCnt_q <= 8'h00;
    end else begin
      case (guardSt_q)
        GuardIdle: begin
          if (txOk && scMode && guardTime != 8'h00) begin
            guardSt_q  <= GuardWait;
            guardCnt_q <= guardTime;
          end else if (txOk) begin
            guardSt_q <= GuardDone;
          end
        end
        GuardWait: begin
          if (!unitEn) begin
            guardSt_q <= GuardIdle;
          end else if (baudTick_q) begin
            guardCnt_q <= guardCnt_q - 8'h01;
            if (guardCnt_q == 8'h01) begin
              guardSt_q <= GuardDone;
            end
          end
        end
        GuardDone: begin
          guardSt_q <= GuardIdle;
        end
        default: begin
          guardSt_q <= GuardIdle;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      txComplete_q <= 1'b0;
    end else begin
      txComplete_q <= (guardSt_q == GuardDone);
    end
  end

  assign txComplete = txComplete_q;

  // ****************************************
  // wakeup source
  // ****************************************
  logic wakeHit;

  always_comb begin
    case (wakeSel)
      WakeAddr:   wakeHit = evt.addrMatch;
      WakeStart:  wakeHit = evt.startDetect;
      WakeRxFull: wakeHit = evt.rxNotEmpty;
      default:    wakeHit = 1'b0;
    endcase
  end

  // ****************************************
  // status, mask, interrupt
  // ****************************************
  assign evtSet = {autoBaud.valid, rxErr, txErr,
                   guardSt_q == GuardDone, wakeHit};

  logic [StsWidth-1:0] stsClr;
  logic [StsWidth-1:0] enMask;
  logic                irq_q;

  assign stsClr = (wrStb && addr == StatusOffset) ?
                  wdata[StsWidth-1:0] : '0;
  assign enMask = mask_q | (StsWidth'(wakeIe) << StsWakePos);

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sts_q <= '0;
    end else begin
      sts_q <= (sts_q & ~stsClr) | evtSet;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      mask_q <= '0;
    end else if (wrStb && addr == MaskOffset) begin
      mask_q <= wdata[StsWidth-1:0];
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(((sts_q & ~stsClr) | evtSet) & enMask);
    end
  end

  assign irq = irq_q;

  // ****************************************
  // read data
  // ****************************************
  logic [31:0] rdMux;

  always_comb begin
    rdMux = 32'h0;
    case (addr)
      ModeOffset:   rdMux = {28'h0, mode_q};
      CtrlOffset:   rdMux = ctrl_q;
      BaudOffset:   rdMux = {16'h0, baud_q};
      GuardOffset:  rdMux = {16'h0, guard_q};
      StatusOffset: rdMux = {27'h0, sts_q};
      MaskOffset:   rdMux = {27'h0, mask_q};
      StateOffset:  rdMux = {16'h0, guardCnt_q, 1'b0, rxTries_q,
                             1'b0, txTries_q};
      default:      rdMux = 32'h0;
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rdata_qq <= 32'h0;
    end else begin
      rdata_qq <= rdStb ? rdMux : 32'h0;
    end
  end

endmodule : ubg_config
`default_nettype wire

// >>> test/ubg_config_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// port checker
// ****************************************
module ubg_config_checker
  import ubg_pkg::*;
(
  input wire logic          clock,
  input wire logic          resetn,
  input wire logic [7:0]    addr,
  input wire logic [31:0]   wdata,
  input wire logic          wrStb,
  input wire logic          rdStb,
  input wire logic [31:0]   rdata,
  input wire ubg_evt_t      evt,
  input wire ubg_autobaud_t autoBaud,
  input wire logic          rtsFlowLevel,
  input wire logic          rtsPin,
  input wire logic          baudTick,
  input wire logic          irdaTick,
  input wire logic          smartcardClock,
  input wire logic          txResend,
  input wire logic          rxRetryReq,
  input wire logic          txComplete,
  input wire logic          irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);

  chk_rdata_idle_slot: assert property (
    !$past(rdStb) |-> rdata == 32'h0) else $error("read data outside slot");
  chk_resend_has_nack: assert property (
    txResend |-> $past(evt.txFrameDone && evt.txNack))
    else $error("resend without nack");
  chk_retry_has_cause: assert property (
    rxRetryReq |-> $past(evt.rxParityErr)) else $error("retry without error");
  chk_resend_one_cycle: assert property (
    txResend |=> !txResend) else $error("resend pulse too long");
  chk_done_one_cycle: assert property (
    txComplete |=> !txComplete) else $error("complete pulse too long");
  chk_done_after_frame: assert property (
    txComplete |-> !evt.txFrameActive) else $error("complete inside frame");
  chk_irq_fall_write: assert property (
    $fell(irq) |-> $past(wrStb)) else $error("irq dropped without write");
  chk_irq_rise_cause: assert property (
    $rose(irq) |-> $past(wrStb || autoBaud.valid || (|evt)) ||
      $past(wrStb, 2))
    else $error("irq raised without cause");
endmodule : ubg_config_checker
`default_nettype wire

// >>> test/ubg_line_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// far side: frame on the wire, card reply
// ****************************************
module ubg_line_model
  import ubg_pkg::*;
#(
  parameter int FrameLen = 10
)
(
  input  wire logic     clock,
  input  wire logic     resetn,
  input  wire logic     sendReq,
  input  wire logic     nackReply,
  input  wire ubg_evt_t extra,
  output ubg_evt_t      evt
);
  int   cnt;
  logic busy;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      busy <= 1'b0;
      cnt  <= 0;
    end else if (sendReq && !busy) begin
      busy <= 1'b1;
      cnt  <= FrameLen;
    end else if (busy) begin
      cnt  <= cnt - 1;
      busy <= (cnt != 1);
    end
  end
  always_comb begin
    evt               = extra;
    evt.txFrameActive = busy;
    evt.txFrameDone   = busy && (cnt == 1);
    evt.txNack        = busy && (cnt == 1) && nackReply;
  end
endmodule : ubg_line_model
`default_nettype wire

// >>> test/ubg_config_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ubg_config_tb;
  import ubg_pkg::*;
  localparam int FrameLen = 10;
  logic          clock, resetn, wrStb, rdStb, rtsFlowLevel, sendReq;
  logic          nackReply, rtsPin, baudTick, irdaTick, scClk, txResend;
  logic          rxRetryReq, txComplete, irq, res, mid, fin;
  logic [7:0]    addr;
  logic [31:0]   wdata, rdata, got;
  ubg_evt_t      evt, extra;
  ubg_autobaud_t autoBaud;
  int            fails, checksDone, at, nb, ni, ns;

  ubg_config i_dut (.clock(clock), .resetn(resetn), .addr(addr),
    .wdata(wdata), .wrStb(wrStb), .rdStb(rdStb), .rdata(rdata), .evt(evt),
    .autoBaud(autoBaud), .rtsFlowLevel(rtsFlowLevel), .rtsPin(rtsPin),
    .baudTick(baudTick), .irdaTick(irdaTick), .smartcardClock(scClk),
    .txResend(txResend), .rxRetryReq(rxRetryReq), .txComplete(txComplete),
    .irq(irq));
  ubg_line_model #(.FrameLen(FrameLen)) i_line (.clock(clock),
    .resetn(resetn), .sendReq(sendReq), .nackReply(nackReply),
    .extra(extra), .evt(evt));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic chk(input string name, input logic [31:0] exp,
                     input logic [31:0] seen);
    checksDone++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wrStb <= 1'b1;
    @(posedge clock);
    wrStb <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    addr  <= a;
    rdStb <= 1'b1;
    @(posedge clock);
    rdStb <= 1'b0;
    #1;
    d = rdata;
  endtask : rd

  task automatic pulse(input ubg_evt_t e);
    @(posedge clock);
    extra <= e;
    @(posedge clock);
    extra <= '0;
    #1;
  endtask : pulse

  task automatic frame(input logic nack);
    res = 1'b0;
    at  = 0;
    @(posedge clock);
    sendReq   <= 1'b1;
    nackReply <= nack;
    @(posedge clock);
    sendReq <= 1'b0;
    for (int i = 1; i < FrameLen + 30; i++) begin
      @(posedge clock);
      #1;
      if (txResend === 1'b1) res = 1'b1;
      if (txComplete === 1'b1 && at == 0) at = i;
      if (i == FrameLen / 2) mid = rtsPin;
    end
    fin = rtsPin;
  endtask : frame

  task automatic ticks();
    logic lastSc;
    nb = 0;
    ni = 0;
    ns = 0;
    lastSc = scClk;
    repeat (60) begin
      @(posedge clock);
      #1;
      nb += int'(baudTick === 1'b1);
      ni += int'(irdaTick === 1'b1);
      ns += int'(scClk === 1'b1 && lastSc === 1'b0);
      lastSc = scClk;
    end
  endtask : ticks

  task automatic conclude();
    $display("checks %0d mismatches %0d", checksDone, fails);
    if (fails == 0 && checksDone > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : conclude

  // ****************************************
  // scenarios
  // ****************************************
  task automatic regs();
    rd(BaudOffset, got);
    chk("baud reset", 32'h0, got);
    rd(GuardOffset, got);
    chk("guard reset", 32'h0, got);
    rd(8'h30, got);
    chk("unmapped", 32'h0, got);
    wr(BaudOffset, 32'hffff_abc5);
    rd(BaudOffset, got);
    chk("baud fields", 32'h0000_abc5, got);
    wr(ModeOffset, 32'h1);
    wr(BaudOffset, 32'h1234);
    wr(GuardOffset, 32'h0201);
    rd(BaudOffset, got);
    chk("baud locked", 32'h0000_abc5, got);
    rd(GuardOffset, got);
    chk("guard locked", 32'h0, got);
    @(posedge clock);
    autoBaud <= '{valid: 1'b1, value: 16'h0020};
    @(posedge clock);
    autoBaud <= '0;
    rd(BaudOffset, got);
    chk("auto baud", 32'h0020, got);
    wr(ModeOffset, 32'h0);
    wr(GuardOffset, 32'h0223);
  endtask : regs

  task automatic clocks();
    wr(ModeOffset, 32'h3);
    ticks();
    chk("baud ticks", 32'h1, 32'(nb inside {[29:31]}));
    chk("card clock", 32'h1, 32'(ns inside {[9:11]}));
    wr(ModeOffset, 32'h0);
    wr(GuardOffset, 32'h0201);
    wr(ModeOffset, 32'h5);
    ticks();
    chk("irda normal", 32'h0, 32'(ni));
    wr(ModeOffset, 32'h0);
    wr(GuardOffset, 32'h0203);
    wr(ModeOffset, 32'hd);
    ticks();
    chk("irda ticks", 32'h1, 32'(ni inside {[19:21]}));
    wr(ModeOffset, 32'h0);
  endtask : clocks

  task automatic drive();
    for (int p = 0; p < 2; p++) begin
      wr(CtrlOffset, (32'h1 << CtrlDrvEnPos) | (32'(p) << CtrlDrvPolPos));
      frame(1'b0);
      chk("rts active", 32'(p == 0), 32'(mid));
      chk("rts idle", 32'(p != 0), 32'(fin));
    end
    wr(CtrlOffset, 32'h0);
    rtsFlowLevel <= 1'b0;
    frame(1'b0);
    chk("rts flow", 32'h0, 32'(mid));
  endtask : drive

  task automatic retries();
    wr(ModeOffset, 32'h2);
    for (int r = 0; r < 3; r++) begin
      wr(CtrlOffset, 32'(r) << CtrlRetryLsb);
      wr(ModeOffset, 32'h3);
      for (int n = 0; n <= r; n++) begin
        frame(1'b1);
        chk("resend", 32'(n < r), 32'(res));
      end
      rd(StatusOffset, got);
      chk("tx error", 32'h1, 32'(got[StsTxErrPos]));
      wr(StatusOffset, 32'h1 << StsTxErrPos);
      wr(ModeOffset, 32'h2);
    end
    wr(ModeOffset, 32'h3);
    frame(1'b0);
    chk("guard", 32'h1, 32'(at > FrameLen + 2 && at < FrameLen + 20));
    wr(ModeOffset, 32'h2);
    wr(CtrlOffset, 32'h1 << CtrlRetryLsb);
    wr(ModeOffset, 32'h3);
    for (int n = 0; n < 2; n++) begin
      pulse('{rxParityErr: 1'b1, default: 1'b0});
      chk("rx retry", 32'(n == 0), 32'(rxRetryReq));
    end
    rd(StatusOffset, got);
    chk("rx error", 32'h1, 32'(got[StsRxErrPos]));
    wr(StatusOffset, 32'h1f);
    wr(ModeOffset, 32'h0);
  endtask : retries

  task automatic wakeup();
    for (int s = 0; s < 4; s++) begin
      wr(CtrlOffset, 32'(s) << CtrlWakeSelLsb);
      for (int k = 0; k < 3; k++) begin
        pulse(ubg_evt_t'(8'(8'h4 >> k)));
        rd(StatusOffset, got);
        chk("wake flag", 32'(s == (k == 0 ? 0 : k + 1)), 32'(got[0]));
        wr(StatusOffset, 32'h1);
      end
    end
    wr(CtrlOffset, (32'h2 << CtrlWakeSelLsb) | (32'h1 << CtrlWakeIePos));
    pulse('{startDetect: 1'b1, default: 1'b0});
    chk("wake irq", 32'h1, 32'(irq));
    wr(StatusOffset, 32'h1);
    repeat (2) @(posedge clock);
    #1;
    chk("irq cleared", 32'h0, 32'(irq));
    wr(CtrlOffset, 32'h2 << CtrlWakeSelLsb);
    pulse('{startDetect: 1'b1, default: 1'b0});
    chk("irq masked", 32'h0, 32'(irq));
    wr(MaskOffset, 32'h1);
    repeat (2) @(posedge clock);
    #1;
    chk("irq unmasked", 32'h1, 32'(irq));
    wr(StatusOffset, 32'h1);
  endtask : wakeup

  initial begin
    fails        = 0;
    checksDone   = 0;
    resetn       = 1'b0;
    wrStb        = 1'b0;
    rdStb        = 1'b0;
    addr         = 8'h00;
    wdata        = 32'h0;
    rtsFlowLevel = 1'b1;
    sendReq      = 1'b0;
    nackReply    = 1'b0;
    extra        = '0;
    autoBaud     = '0;
    repeat (6) @(posedge clock);
    resetn <= 1'b1;
    regs();
    clocks();
    drive();
    retries();
    wakeup();
    conclude();
  end
endmodule : ubg_config_tb

bind ubg_config ubg_config_checker i_chk (.clock(clock), .resetn(resetn),
  .addr(addr), .wdata(wdata), .wrStb(wrStb), .rdStb(rdStb), .rdata(rdata),
  .evt(evt), .autoBaud(autoBaud), .rtsFlowLevel(rtsFlowLevel),
  .rtsPin(rtsPin), .baudTick(baudTick), .irdaTick(irdaTick),
  .smartcardClock(smartcardClock), .txResend(txResend),
  .rxRetryReq(rxRetryReq), .txComplete(txComplete), .irq(irq));
`default_nettype wire
